// ### logic/scratchpad_write_verify_copy.sv
// Scratchpad write, read-back and copy command interpreter
//
// Functional notes
// - Data stored from byte offset; ending recorded.
// - Incomplete last byte dropped; partial flag set.
// - CRC cleared, then command, address, data.
// - Full scratchpad: CRC on sixteen read slots.
// - Returned CRC is bit-inverted.
// - Upper seven address bits forced zero.
// - Read sends address, status, then data.
// - Reading past scratchpad end returns ones.
// - After good write both flags clear.
// - Match sets copy flag, starts copy.
// - Copy begin through ending offset to memory.
// - Bus reset ignored while copy runs.
// - After copy, alternating ones and zeros.
// - Copy flag cleared only by write command.
// - Regular speed by default; overdrive on request.
// - Status: ending offset, partial, zero, copy flag.
// - All bytes travel least significant bit first.
`timescale 1ns/1ps
module scratchpad_write_verify_copy #(
  parameter int unsigned COPY_CYCLES_P = scratch_pkg::COPY_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic func_start_i,
  input wire logic rx_valid_i,
  input wire logic rx_bit_i,
  input wire logic bus_reset_i,
  input wire logic overdrive_req_i,
  input wire logic std_speed_req_i,
  output logic tx_valid_o,
  output logic tx_bit_o,
  input wire logic tx_ready_i,
  output logic mem_wr_o,
  output logic [scratch_pkg::MEM_AW-1:0] mem_addr_o,
  output logic [7:0] mem_data_o,
  output logic copy_busy_o,
  output logic speed_select_o,
  output logic partial_byte_flag_o,
  output logic copy_accepted_flag_o,
  output logic [scratch_pkg::OFF_W-1:0] ending_offset_o
);
  import scratch_pkg::*;

  initial begin
    if (COPY_CYCLES_P < SP_BYTES + 1 || COPY_CYCLES_P > 65535) begin
      $error("COPY_CYCLES_P must lie between 33 and 65535");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  seq_state_t state_q;
  logic [1:0] idx_q;
  logic [5:0] rd_off_q;
  logic [4:0] cur_off_q;
  logic auth_bad_q;
  logic copy_wr_done_q;
  logic [15:0] copy_timer_q;
  logic [7:0] rx_sr_q;
  logic [2:0] rx_cnt_q;
  logic [15:0] crc_q;
  logic [7:0] ta_low_q;
  logic [7:0] ta_high_q;
  logic [7:0] scratch_q [SP_BYTES];
  logic [15:0] tx_sr_q;
  logic [4:0] tx_left_q;
  logic byte_done;
  logic [7:0] byte_val;
  logic reset_act;
  logic [7:0] es_byte;
  logic [7:0] auth_expect;
  logic auth_bad;
  logic load_req;
  logic load_take;
  logic [15:0] load_val;
  logic [4:0] load_len;
  logic buf_in_ready;
  logic buf_push;

  //////////////////////////////////////////////////////////////////////////////
  // Byte assembly and decode helpers

  assign byte_done = rx_valid_i && (rx_cnt_q == LAST_BIT);
  assign byte_val = {rx_bit_i, rx_sr_q[7:1]};
  assign reset_act = bus_reset_i && (state_q != ST_COPY);
  assign es_byte = {copy_accepted_flag_o, 1'b0, partial_byte_flag_o, ending_offset_o};
  assign buf_push = (tx_left_q != 5'd0) && buf_in_ready;
  assign load_take = load_req && (tx_left_q == 5'd0);
  assign auth_bad = auth_bad_q || (byte_val != auth_expect);

  always_comb begin
    case (idx_q)
      2'd0: auth_expect = ta_low_q;
      2'd1: auth_expect = ta_high_q;
      default: auth_expect = es_byte;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_sr_q <= 8'h00;
      rx_cnt_q <= 3'h0;
    end else if (bus_reset_i || func_start_i) begin
      rx_cnt_q <= 3'h0;
    end else if (rx_valid_i) begin
      rx_sr_q <= byte_val;
      rx_cnt_q <= rx_cnt_q + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      idx_q <= 2'd0;
      rd_off_q <= 6'h00;
      cur_off_q <= 5'h00;
      auth_bad_q <= 1'b0;
      copy_wr_done_q <= 1'b0;
      copy_timer_q <= 16'h0000;
    end else if (reset_act) begin
      state_q <= ST_IDLE;
      idx_q <= 2'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (func_start_i) begin
            state_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (byte_done) begin
            idx_q <= 2'd0;
            auth_bad_q <= 1'b0;
            if (byte_val == CMD_WRITE_SP) begin
              state_q <= ST_WADDR;
            end else if (byte_val == CMD_READ_SP) begin
              state_q <= ST_RSEND;
              rd_off_q <= {1'b0, ta_low_q[4:0]};
            end else if (byte_val == CMD_COPY_SP) begin
              state_q <= ST_CAUTH;
            end else begin
              state_q <= ST_HALT;
            end
          end
        end
        ST_WADDR: begin
          if (byte_done) begin
            if (idx_q == 2'd0) begin
              idx_q <= 2'd1;
            end else begin
              state_q <= ST_WDATA;
              cur_off_q <= ta_low_q[4:0];
            end
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            if (cur_off_q == LAST_OFFSET) begin
              state_q <= ST_WCRC;
              idx_q <= 2'd0;
            end else begin
              cur_off_q <= cur_off_q + 5'h01;
            end
          end
        end
        ST_WCRC: begin
          if (load_take) begin
            idx_q <= 2'd1;
          end
        end
        ST_RSEND: begin
          if (load_take) begin
            if (idx_q != 2'd3) begin
              idx_q <= idx_q + 2'd1;
            end else if (!rd_off_q[5]) begin
              rd_off_q <= rd_off_q + 6'h01;
            end
          end
        end
        ST_CAUTH: begin
          if (byte_done) begin
            if (idx_q != 2'd2) begin
              idx_q <= idx_q + 2'd1;
              auth_bad_q <= auth_bad;
            end else if (auth_bad) begin
              state_q <= ST_HALT;
            end else begin
              state_q <= ST_COPY;
              cur_off_q <= ta_low_q[4:0];
              copy_wr_done_q <= 1'b0;
              copy_timer_q <= 16'h0000;
            end
          end
        end
        ST_COPY: begin
          copy_timer_q <= copy_timer_q + 16'h0001;
          if (!copy_wr_done_q) begin
            if (cur_off_q == ending_offset_o) begin
              copy_wr_done_q <= 1'b1;
            end else begin
              cur_off_q <= cur_off_q + 5'h01;
            end
          end else if (copy_timer_q >= 16'(COPY_CYCLES_P - 1)) begin
            state_q <= ST_CDONE;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address, status flags and speed

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ta_low_q <= 8'h00;
      ta_high_q <= 8'h00;
    end else if (!reset_act && state_q == ST_WADDR && byte_done) begin
      if (idx_q == 2'd0) begin
        ta_low_q <= byte_val;
      end else begin
        ta_high_q <= byte_val & ADDR_HIGH_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      partial_byte_flag_o <= 1'b0;
      copy_accepted_flag_o <= 1'b0;
      ending_offset_o <= 5'h00;
    end else begin
      if (reset_act && state_q == ST_WDATA && rx_cnt_q != 3'h0) begin
        partial_byte_flag_o <= 1'b1;
      end else if (state_q == ST_CMD && byte_done && byte_val == CMD_WRITE_SP) begin
        partial_byte_flag_o <= 1'b0;
      end
      if (state_q == ST_CMD && byte_done && byte_val == CMD_WRITE_SP) begin
        copy_accepted_flag_o <= 1'b0;
      end else if (!reset_act && state_q == ST_CAUTH && byte_done && idx_q == 2'd2
                   && !auth_bad) begin
        copy_accepted_flag_o <= 1'b1;
      end
      if (!reset_act && state_q == ST_WDATA && byte_done) begin
        ending_offset_o <= cur_off_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      speed_select_o <= SPEED_RESET;
    end else if (overdrive_req_i) begin
      speed_select_o <= 1'b1;
    end else if (std_speed_req_i) begin
      speed_select_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Scratchpad storage and CRC

  always_ff @(posedge ref_clk_i) begin
    if (!reset_act && state_q == ST_WDATA && byte_done) begin
      scratch_q[cur_off_q] <= byte_val;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crc_q <= CRC_INIT;
    end else if (func_start_i) begin
      crc_q <= CRC_INIT;
    end else if (rx_valid_i && !reset_act
                 && (state_q == ST_CMD || state_q == ST_WADDR || state_q == ST_WDATA)) begin
      if (crc_q[0] ^ rx_bit_i) begin
        crc_q <= (crc_q >> 1) ^ CRC_POLY;
      end else begin
        crc_q <= crc_q >> 1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read slot data source

  always_comb begin
    load_req = 1'b0;
    load_val = 16'h0000;
    load_len = 5'h00;
    case (state_q)
      ST_RSEND: begin
        load_req = 1'b1;
        load_len = BYTE_BITS;
        if (idx_q == 2'd0) begin
          load_val = {8'h00, ta_low_q};
        end else if (idx_q == 2'd1) begin
          load_val = {8'h00, ta_high_q};
        end else if (idx_q == 2'd2) begin
          load_val = {8'h00, es_byte};
        end else if (rd_off_q[5]) begin
          load_val = {8'h00, FILL_ONES};
        end else begin
          load_val = {8'h00, scratch_q[rd_off_q[4:0]]};
        end
      end
      ST_WCRC: begin
        load_req = (idx_q == 2'd0);
        load_len = CRC_BITS;
        load_val = ~crc_q;
      end
      ST_CDONE: begin
        load_req = 1'b1;
        load_len = BYTE_BITS;
        load_val = {8'h00, ALT_PATTERN};
      end
      default: begin
        load_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_sr_q <= 16'h0000;
      tx_left_q <= 5'h00;
    end else if (reset_act) begin
      tx_left_q <= 5'h00;
    end else if (load_take) begin
      tx_sr_q <= load_val;
      tx_left_q <= load_len;
    end else if (buf_push) begin
      tx_sr_q <= tx_sr_q >> 1;
      tx_left_q <= tx_left_q - 5'h01;
    end
  end

  two_entry_buffer #(
    .WIDTH(1),
    .DEPTH(2)
  ) u_tx_buffer (
    .clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .flush_i(reset_act),
    .in_valid_i(tx_left_q != 5'h00),
    .in_data_i(tx_sr_q[0]),
    .in_ready_o(buf_in_ready),
    .out_valid_o(tx_valid_o),
    .out_data_o(tx_bit_o),
    .out_ready_i(tx_ready_i)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Main memory write port

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_wr_o <= 1'b0;
      mem_addr_o <= '0;
      mem_data_o <= 8'h00;
      copy_busy_o <= 1'b0;
    end else begin
      mem_wr_o <= (state_q == ST_COPY) && !copy_wr_done_q;
      mem_addr_o <= {ta_high_q[0], ta_low_q[7:5], cur_off_q};
      mem_data_o <= scratch_q[cur_off_q];
      copy_busy_o <= (state_q == ST_COPY);
    end
  end

endmodule

// ### logic/scratch_pkg.sv
// Constants and types for the scratchpad command interpreter
package scratch_pkg;

  // Function command codes
  localparam logic [7:0] CMD_WRITE_SP = 8'h0f;
  localparam logic [7:0] CMD_READ_SP = 8'haa;
  localparam logic [7:0] CMD_COPY_SP = 8'h5a;

  // Address and offset layout
  localparam int unsigned OFF_W = 5;
  localparam int unsigned MEM_AW = 9;
  localparam int unsigned SP_BYTES = 32;
  localparam logic [4:0] LAST_OFFSET = 5'h1f;
  localparam logic [7:0] ADDR_HIGH_MASK = 8'h01;

  // End-status byte fields
  localparam int unsigned ES_PF_BIT = 5;
  localparam int unsigned ES_ZERO_BIT = 6;
  localparam int unsigned ES_AA_BIT = 7;

  // CRC16, reflected form of x^16 + x^15 + x^2 + 1
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // Filler patterns on read slots
  localparam logic [7:0] FILL_ONES = 8'hff;
  localparam logic [7:0] ALT_PATTERN = 8'h55;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] CRC_BITS = 5'h10;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Copy duration
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned COPY_TIME_NS = 30000;
  localparam int unsigned COPY_CYCLES = (COPY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Speed select reset value
  localparam logic SPEED_RESET = 1'b0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CMD = 4'b0001,
    ST_WADDR = 4'b0010,
    ST_WDATA = 4'b0011,
    ST_WCRC = 4'b0100,
    ST_RSEND = 4'b0101,
    ST_CAUTH = 4'b0110,
    ST_COPY = 4'b0111,
    ST_CDONE = 4'b1000,
    ST_HALT = 4'b1001
  } seq_state_t;

endpackage

// ### logic/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  initial begin
    if (DEPTH != 2 || WIDTH < 1) begin
      $error("two_entry_buffer supports DEPTH 2 and WIDTH of at least 1 only");
    end
  end

  logic [1:0] count_q;
  logic [1:0] count_d;
  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] tail_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != 2'd2);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 2'd1;
    end else if (pop && !push) begin
      count_d = count_q - 2'd1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_q <= 2'd0;
      out_valid_o <= 1'b0;
    end else if (flush_i) begin
      count_q <= 2'd0;
      out_valid_o <= 1'b0;
    end else begin
      count_q <= count_d;
      out_valid_o <= (count_d != 2'd0);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      head_q <= '0;
      tail_q <= '0;
    end else begin
      if (count_q == 2'd0 && push) begin
        head_q <= in_data_i;
      end else if (count_q == 2'd1 && push && pop) begin
        head_q <= in_data_i;
      end else if (count_q == 2'd1 && push) begin
        tail_q <= in_data_i;
      end else if (count_q == 2'd2 && pop) begin
        head_q <= tail_q;
        if (push) begin
          tail_q <= in_data_i;
        end
      end
    end
  end

  assign out_data_o = head_q;

endmodule

// ### tb/scratch_monitor.sv
// Port checker for the scratchpad command interpreter
`timescale 1ns/1ps
module scratch_monitor
  import scratch_pkg::*;
#(
  parameter int unsigned COPY_CYCLES_P = 40
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic func_start_i,
  input wire logic rx_valid_i,
  input wire logic rx_bit_i,
  input wire logic bus_reset_i,
  input wire logic overdrive_req_i,
  input wire logic std_speed_req_i,
  input wire logic tx_valid_o,
  input wire logic tx_bit_o,
  input wire logic tx_ready_i,
  input wire logic mem_wr_o,
  input wire logic [scratch_pkg::MEM_AW-1:0] mem_addr_o,
  input wire logic [7:0] mem_data_o,
  input wire logic copy_busy_o,
  input wire logic speed_select_o,
  input wire logic partial_byte_flag_o,
  input wire logic copy_accepted_flag_o,
  input wire logic [scratch_pkg::OFF_W-1:0] ending_offset_o
);
  int unsigned busy_cnt_q;
  logic [4:0] next_off_q;
  // Busy length and expected next copy offset
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_cnt_q <= 0;
      next_off_q <= 5'h00;
    end else begin
      busy_cnt_q <= copy_busy_o ? busy_cnt_q + 1 : 0;
      next_off_q <= mem_addr_o[4:0] + 5'h01;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  a_tx_hold_stall: assert property (
    tx_valid_o && !tx_ready_i && !bus_reset_i |=> tx_valid_o && $stable(tx_bit_o))
    else $error("read bit changed while stalled");
  a_wr_needs_accept: assert property (
    mem_wr_o |-> copy_accepted_flag_o) else $error("memory write without accept");
  a_accept_starts_copy: assert property (
    $rose(copy_accepted_flag_o) |-> ##[1:3] mem_wr_o) else $error("copy did not start");
  a_accept_clear_cause: assert property (
    $fell(copy_accepted_flag_o) |->
      $past(rx_valid_i) || $past(rx_valid_i, 2) || $past(rx_valid_i, 3))
    else $error("accept flag cleared without a command");
  a_no_tx_in_copy: assert property (
    copy_busy_o |-> !tx_valid_o) else $error("read bit during copy");
  a_copy_length: assert property (
    $fell(copy_busy_o) |-> busy_cnt_q >= COPY_CYCLES_P - 1) else $error("copy too short");
  a_copy_steps: assert property (
    mem_wr_o && $past(mem_wr_o) |-> mem_addr_o[4:0] == next_off_q)
    else $error("copy offsets not consecutive");
  a_speed_up: assert property (
    overdrive_req_i |=> speed_select_o) else $error("speed select not set");
  a_speed_down: assert property (
    std_speed_req_i && !overdrive_req_i |=> !speed_select_o) else $error("speed not cleared");
  a_speed_hold: assert property (
    !overdrive_req_i && !std_speed_req_i |=> $stable(speed_select_o))
    else $error("speed select changed alone");
  a_reset_flush: assert property (
    bus_reset_i && !copy_busy_o && !$rose(copy_accepted_flag_o) |=> !tx_valid_o)
    else $error("bus reset did not flush");
  c_copy: cover property ($rose(copy_busy_o));
  c_partial: cover property ($rose(partial_byte_flag_o));
  c_stall: cover property (tx_valid_o && !tx_ready_i);
  c_speed: cover property ($rose(speed_select_o));
endmodule
bind scratchpad_write_verify_copy scratch_monitor #(.COPY_CYCLES_P(COPY_CYCLES_P)) mon (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .func_start_i(func_start_i),
  .rx_valid_i(rx_valid_i), .rx_bit_i(rx_bit_i), .bus_reset_i(bus_reset_i),
  .overdrive_req_i(overdrive_req_i), .std_speed_req_i(std_speed_req_i),
  .tx_valid_o(tx_valid_o), .tx_bit_o(tx_bit_o), .tx_ready_i(tx_ready_i),
  .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
  .copy_busy_o(copy_busy_o), .speed_select_o(speed_select_o),
  .partial_byte_flag_o(partial_byte_flag_o), .copy_accepted_flag_o(copy_accepted_flag_o),
  .ending_offset_o(ending_offset_o));

// ### tb/slot_master_model.sv
// Bus master slot model that pops read bits and packs bytes
`timescale 1ns/1ps
module slot_master_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic clr_i,
  input wire logic slow_i,
  input wire logic tx_valid_i,
  input wire logic tx_bit_i,
  output logic tx_ready_o,
  output logic [7:0] byte_o,
  output logic byte_stb_o
);
  logic [1:0] stall_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  // Slow mode offers a read slot one cycle in three
  assign tx_ready_o = !slow_i || (stall_q == 2'h2);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stall_q <= 2'h0;
    end else begin
      stall_q <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
    end
  end
  // Bits arrive least significant first; a bus reset restarts the byte
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      byte_o <= 8'h00;
      byte_stb_o <= 1'b0;
    end else begin
      byte_stb_o <= 1'b0;
      if (clr_i) begin
        cnt_q <= 3'h0;
      end else if (tx_valid_i && tx_ready_o) begin
        sh_q <= {tx_bit_i, sh_q[7:1]};
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          byte_o <= {tx_bit_i, sh_q[7:1]};
          byte_stb_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the scratchpad command interpreter
`timescale 1ns/1ps
module tb_top;
  import scratch_pkg::*;
  localparam int unsigned CP = 40;
  logic ref_clk_i, arst_n_i, func_start_i, rx_valid_i, rx_bit_i, bus_reset_i;
  logic overdrive_req_i, std_speed_req_i, tx_valid_o, tx_bit_o, tx_ready_i, mem_wr_o;
  logic copy_busy_o, speed_select_o, partial_byte_flag_o, copy_accepted_flag_o, got_stb, slow;
  logic [MEM_AW-1:0] mem_addr_o;
  logic [7:0] mem_data_o, got_byte;
  logic [OFF_W-1:0] ending_offset_o;
  logic [16:0] mem_q[$];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  scratchpad_write_verify_copy #(.COPY_CYCLES_P(CP)) uut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .func_start_i(func_start_i),
    .rx_valid_i(rx_valid_i), .rx_bit_i(rx_bit_i), .bus_reset_i(bus_reset_i),
    .overdrive_req_i(overdrive_req_i), .std_speed_req_i(std_speed_req_i),
    .tx_valid_o(tx_valid_o), .tx_bit_o(tx_bit_o), .tx_ready_i(tx_ready_i),
    .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
    .copy_busy_o(copy_busy_o), .speed_select_o(speed_select_o),
    .partial_byte_flag_o(partial_byte_flag_o), .copy_accepted_flag_o(copy_accepted_flag_o),
    .ending_offset_o(ending_offset_o));
  slot_master_model partner (.clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clr_i(bus_reset_i),
    .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_bit_i(tx_bit_o), .tx_ready_o(tx_ready_i),
    .byte_o(got_byte), .byte_stb_o(got_stb));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (mem_wr_o === 1'b1) mem_q.push_back({mem_addr_o, mem_data_o});
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send_byte(input logic [7:0] b, input int nbits = 8);
    for (int i = 0; i < nbits; i++) begin
      @(posedge ref_clk_i);
      rx_valid_i <= 1'b1;
      rx_bit_i <= b[i];
      @(posedge ref_clk_i);
      rx_valid_i <= 1'b0;
    end
  endtask
  task automatic begin_cmd(input logic [7:0] cmd);
    @(posedge ref_clk_i);
    bus_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    bus_reset_i <= 1'b0;
    func_start_i <= 1'b1;
    @(posedge ref_clk_i);
    func_start_i <= 1'b0;
    send_byte(cmd);
  endtask
  task automatic expect_byte(input string what, input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while (got_stb !== 1'b1 && n < 600) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(what, {11'h000, got_stb, got_byte}, {11'h001, exp});
  endtask
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c >> 1) ^ ((c[0] ^ b[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write_crc();
    logic [15:0] c;
    c = crc_byte(crc_byte(crc_byte(CRC_INIT, CMD_WRITE_SP), 8'h3c), 8'hfe);
    begin_cmd(CMD_WRITE_SP);
    send_byte(8'h3c);
    send_byte(8'hfe);
    for (int i = 0; i < 4; i++) begin
      send_byte(8'h10 + 8'(i));
      c = crc_byte(c, 8'h10 + 8'(i));
    end
    expect_byte("crc low", ~c[7:0]);
    expect_byte("crc high", ~c[15:8]);
    check("ending offset", 20'(ending_offset_o), 20'(LAST_OFFSET));
    check("flags", 20'({partial_byte_flag_o, copy_accepted_flag_o}), 20'h0);
  endtask
  task automatic t_read();
    slow = 1'b1;
    begin_cmd(CMD_READ_SP);
    expect_byte("addr low", 8'h3c);
    expect_byte("addr high", 8'h00);
    expect_byte("status", 8'h1f);
    for (int i = 0; i < 4; i++) expect_byte("data", 8'h10 + 8'(i));
    expect_byte("past end", FILL_ONES);
    expect_byte("past end", FILL_ONES);
    slow = 1'b0;
  endtask
  task automatic t_copy();
    int n;
    begin_cmd(CMD_COPY_SP);
    send_byte(8'h3c);
    send_byte(8'h00);
    send_byte(8'h1f);
    @(posedge ref_clk_i);
    bus_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    bus_reset_i <= 1'b0;
    @(negedge ref_clk_i);
    check("accepted", 20'(copy_accepted_flag_o), 20'h1);
    check("busy", 20'(copy_busy_o), 20'h1);
    n = 0;
    while (copy_busy_o === 1'b1 && n < 300) begin
      @(negedge ref_clk_i);
      n++;
    end
    check("copy time", 20'((n >= CP - 4) && (n < 300)), 20'h1);
    check("copied bytes", 20'(mem_q.size()), 20'h4);
    foreach (mem_q[i]) check("copied", 20'(mem_q[i]), {3'h0, 9'h03c + 9'(i), 8'h10 + 8'(i)});
    expect_byte("done pattern", ALT_PATTERN);
    expect_byte("done pattern", ALT_PATTERN);
    begin_cmd(CMD_READ_SP);
    expect_byte("addr low", 8'h3c);
    expect_byte("addr high", 8'h00);
    expect_byte("status", 8'h9f);
  endtask
  task automatic t_partial();
    int sz;
    begin_cmd(CMD_WRITE_SP);
    send_byte(8'h05);
    send_byte(8'h01);
    send_byte(8'ha5);
    send_byte(8'h07, 3);
    @(negedge ref_clk_i);
    check("accepted", 20'(copy_accepted_flag_o), 20'h0);
    begin_cmd(CMD_READ_SP);
    expect_byte("addr low", 8'h05);
    expect_byte("addr high", 8'h01);
    expect_byte("status", 8'h25);
    expect_byte("data", 8'ha5);
    check("partial", 20'(partial_byte_flag_o), 20'h1);
    sz = mem_q.size();
    begin_cmd(CMD_COPY_SP);
    send_byte(8'h05);
    send_byte(8'h01);
    send_byte(8'h24);
    repeat (60) @(negedge ref_clk_i);
    check("refused copy", {copy_accepted_flag_o, 19'(mem_q.size() - sz)}, 20'h0);
    begin_cmd(8'hc3);
    send_byte(8'h0f);
    repeat (4) @(negedge ref_clk_i);
    check("unknown command", {tx_valid_o, 14'h0000, ending_offset_o}, 20'h00005);
  endtask
  task automatic t_speed();
    @(posedge ref_clk_i);
    overdrive_req_i <= 1'b1;
    @(posedge ref_clk_i);
    overdrive_req_i <= 1'b0;
    std_speed_req_i <= 1'b1;
    @(negedge ref_clk_i);
    check("overdrive", 20'(speed_select_o), 20'h1);
    @(posedge ref_clk_i);
    std_speed_req_i <= 1'b0;
    @(negedge ref_clk_i);
    check("regular", 20'(speed_select_o), 20'h0);
  endtask
  initial begin
    {func_start_i, rx_valid_i, rx_bit_i, bus_reset_i, overdrive_req_i, std_speed_req_i} = '0;
    slow = 1'b0;
    arst_n_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(negedge ref_clk_i);
    check("speed at reset", 20'(speed_select_o), 20'(SPEED_RESET));
    t_write_crc();
    t_read();
    t_copy();
    t_partial();
    t_speed();
    report_and_stop();
  end
endmodule
